// *** hw/rx_status_defines.svh ***
`ifndef RX_STATUS_DEFINES_SVH
`define RX_STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PORT_SEL 8'h4c
`define ADDR_STS_ONE 8'h4d
`define ADDR_STS_TWO 8'h4e

// ----------------------------------------------------------------
// port-select fields
// ----------------------------------------------------------------
`define SEL_PHYS_BIT 6
`define SEL_READ_BIT 4
`define SEL_WEN_HI 1

// ----------------------------------------------------------------
// first status register fields
// ----------------------------------------------------------------
`define ONE_PORT_NUM 6
`define ONE_CRC 5
`define ONE_LOCK_CHG 4
`define ONE_SEQ 3
`define ONE_PARITY 2
`define ONE_PASS 1
`define ONE_LOCK 0

// ----------------------------------------------------------------
// second status register fields
// ----------------------------------------------------------------
`define TWO_LEN_UNST 7
`define TWO_LEN_CHG 6
`define TWO_ENC 5
`define TWO_BUF 4
`define TWO_IMG 3
`define TWO_FREQ 2
`define TWO_CABLE 1
`define TWO_CNT_CHG 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define SEL_RESET 8'h00
`define SEL_READ_RESET 1'b0
`define SEL_WEN_RESET 2'h0
`define STS_RESET 8'h00
`define RD_LATENCY 1

`endif

// *** hw/rx_status_pkg.sv ***
package rx_status_pkg;
  // one register byte and one register address
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
  // sticky events of one port, bit order is the flag bank order
  typedef struct packed {
    logic len_unst;
    logic len_chg;
    logic enc;
    logic buf_ovf;
    logic cnt_chg;
    logic crc;
    logic lock_chg;
    logic seq;
  } event_set_t;
endpackage

// *** hw/rx_port_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// per-port carrier between the register hub and a port bank
interface rx_port_if;
  import rx_status_pkg::*;
  logic lock;
  logic pass;
  logic parity_over;
  logic cable_fault;
  logic frequency_stable_flag;
  logic image_err;
  event_set_t events;
  logic rd_one;
  logic rd_two;
  logic sel_port;
  reg_byte_t sts_one;
  reg_byte_t sts_two;
  modport hub (
    output lock, pass, parity_over, cable_fault, frequency_stable_flag, image_err,
    output events, rd_one, rd_two, sel_port,
    input sts_one, sts_two
  );
  modport bank (
    input lock, pass, parity_over, cable_fault, frequency_stable_flag, image_err,
    input events, rd_one, rd_two, sel_port,
    output sts_one, sts_two
  );
endinterface
`default_nettype wire

// *** hw/rx_sticky_flags.sv ***
`timescale 1ns/1ns
`default_nettype none
// bank of sticky flags, set by hardware, cleared by a read strobe
module rx_sticky_flags #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flags_o
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  if (W < 1)
  begin : g_chk
    $error("rx_sticky_flags needs W of at least 1");
  end

  // set beats clear so an event in the read cycle is kept for the next
  always_comb
  begin
    flags_d = set_i | (flags_q & ~clr_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  assign flags_o = flags_q;

  AST_SET_WINS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (set_i & clr_i) != '0 |=> (flags_q & $past(set_i & clr_i)) == $past(set_i & clr_i))
    else $error("flag lost when set and clear met");
  AST_CLEAR_ONLY: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clr_i & ~set_i) != '0 |=> (flags_q & $past(clr_i & ~set_i)) == '0)
    else $error("flag survived a clear without a set");
endmodule // rx_sticky_flags
`default_nettype wire

// *** hw/rx_port_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defines.svh"
// status pair of one receive port
module rx_port_bank (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  rx_port_if.bank port_io
);
  import rx_status_pkg::*;

  logic lock_prev_q;
  logic lock_prev_d;
  event_set_t set_w;
  event_set_t clr_w;
  event_set_t flags_w;

  // ----------------------------------------------------------------
  // lock history, one cycle behind the live lock level
  // ----------------------------------------------------------------
  always_comb
  begin
    lock_prev_d = port_io.lock;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lock_prev_q <= 1'b0;
    else
      lock_prev_q <= lock_prev_d;
  end

  // event sources and read clears of the sticky bank
  always_comb
  begin
    set_w = port_io.events;
    set_w.lock_chg = port_io.lock ^ lock_prev_q;
    clr_w.crc = port_io.rd_one;
    clr_w.lock_chg = port_io.rd_one;
    clr_w.seq = port_io.rd_one;
    clr_w.len_unst = port_io.rd_two;
    clr_w.len_chg = port_io.rd_two;
    clr_w.enc = port_io.rd_two;
    clr_w.buf_ovf = port_io.rd_two;
    clr_w.cnt_chg = port_io.rd_two;
  end

  rx_sticky_flags #(
    .W($bits(event_set_t))
  ) u_flags (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(set_w),
    .clr_i(clr_w),
    .flags_o(flags_w)
  );

  // levels pass live, event bits come from the sticky bank
  always_comb
  begin
    port_io.sts_one = `STS_RESET;
    port_io.sts_one[`ONE_PORT_NUM] = port_io.sel_port;
    port_io.sts_one[`ONE_CRC] = flags_w.crc;
    port_io.sts_one[`ONE_LOCK_CHG] = flags_w.lock_chg;
    port_io.sts_one[`ONE_SEQ] = flags_w.seq;
    port_io.sts_one[`ONE_PARITY] = port_io.parity_over;
    port_io.sts_one[`ONE_PASS] = port_io.pass;
    port_io.sts_one[`ONE_LOCK] = port_io.lock;
    port_io.sts_two = `STS_RESET;
    port_io.sts_two[`TWO_LEN_UNST] = flags_w.len_unst;
    port_io.sts_two[`TWO_LEN_CHG] = flags_w.len_chg;
    port_io.sts_two[`TWO_ENC] = flags_w.enc;
    port_io.sts_two[`TWO_BUF] = flags_w.buf_ovf;
    port_io.sts_two[`TWO_IMG] = port_io.image_err;
    port_io.sts_two[`TWO_FREQ] = port_io.frequency_stable_flag;
    port_io.sts_two[`TWO_CABLE] = port_io.cable_fault;
    port_io.sts_two[`TWO_CNT_CHG] = flags_w.cnt_chg;
  end

  AST_LOCK_CHANGE_SETS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(port_io.lock) |=> port_io.sts_one[`ONE_LOCK_CHG])
    else $error("lock change not flagged");
  AST_CRC_CLEARS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    port_io.rd_one && !port_io.events.crc |=> !port_io.sts_one[`ONE_CRC])
    else $error("crc flag not cleared by read");
  AST_LEN_UNST_HOLDS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    port_io.sts_two[`TWO_LEN_UNST] && !port_io.rd_two |=> port_io.sts_two[`TWO_LEN_UNST])
    else $error("unstable line flag dropped without read");
endmodule // rx_port_bank
`default_nettype wire

// *** hw/rx_port_status_registers.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defines.svh"

// ----------------------------------------------------------------
// receive port status register pair, two ports behind one select
// ----------------------------------------------------------------

// Summary of operation
// - each status register exists per port; access reaches the selected copy
// - read-port bit of the select register picks port 0 or 1 for reads
// - first register bit 6 returns the selected read port number
// - first register bit 5 flags a control channel crc error, clears on read
// - first register bit 4 flags any lock change since last read, clears on read
// - first register bit 3 flags a control channel sequence error, clears on read
// - first register bit 2 is one while parity count exceeds threshold
// - parity flag ignores reads, drops only when the parity count no longer exceeds threshold
// - first register bit 1 shows live pass criteria status
// - first register bit 0 shows live receiver lock
// - second register bit 7 flags unequal line lengths, held until read
// - second register bit 6 flags a line length change, clears on read
// - second register bit 5 flags a link encoding error, clears on read
// - second register bit 4 flags packet buffer overflow, clears on read
// - second register bit 3 is a live image receive error summary
// - second register bit 1 shows cable fault: no link clock while expected
// - second register bit 0 flags a line count change, clears on read
module rx_port_status_registers #(
  parameter int NUM_PORTS = 2,
  parameter int PAR_CNT_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire rx_status_pkg::reg_addr_t reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire rx_status_pkg::reg_byte_t reg_wdata_i,
  output rx_status_pkg::reg_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  output logic read_port_o,
  output logic [1:0] write_enable_o,
  input wire logic [1:0] lock_i,
  input wire logic [1:0] pass_i,
  input wire logic [1:0] frequency_stable_flag_i,
  input wire logic [1:0] image_err_i,
  input wire logic [1:0] link_expected_i,
  input wire logic [1:0] link_clk_detect_i,
  input wire logic [1:0] crc_err_i,
  input wire logic [1:0] seq_err_i,
  input wire logic [1:0] enc_err_i,
  input wire logic [1:0] buf_ovf_i,
  input wire logic [1:0] len_unstable_i,
  input wire logic [1:0] len_chg_i,
  input wire logic [1:0] cnt_chg_i,
  input wire logic [1:0][PAR_CNT_W-1:0] parity_error_count_i,
  input wire logic [1:0][PAR_CNT_W-1:0] parity_threshold_setting_i
);
  import rx_status_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the select field is a single bit, so exactly two ports are served
  if (NUM_PORTS != 2)
  begin : g_chk_ports
    $error("rx_port_status_registers serves exactly two ports");
  end
  if (PAR_CNT_W < 1)
  begin : g_chk_width
    $error("parity count width must be at least 1");
  end

  // ----------------------------------------------------------------
  // state and wiring
  // ----------------------------------------------------------------
  logic sel_q;
  logic sel_d;
  logic [1:0] wen_q;
  logic [1:0] wen_d;
  reg_byte_t rdata_q;
  reg_byte_t rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  reg_byte_t sts_one_w [2];
  reg_byte_t sts_two_w [2];
  logic acc_sel_w;
  logic acc_one_w;
  logic acc_two_w;
  logic [1:0] par_over_w;

  // address decode, shared by reads and writes
  assign acc_sel_w = (reg_addr_i == `ADDR_PORT_SEL);
  assign acc_one_w = (reg_addr_i == `ADDR_STS_ONE);
  assign acc_two_w = (reg_addr_i == `ADDR_STS_TWO);

  rx_port_if port_if [2] ();

  // ----------------------------------------------------------------
  // per-port banks
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    // parity flag is a live compare; it falls only when the count no
    // longer exceeds the threshold, never because of a status read
    assign par_over_w[p] =
      parity_error_count_i[p] > parity_threshold_setting_i[p];
    assign port_if[p].lock = lock_i[p];
    assign port_if[p].pass = pass_i[p];
    assign port_if[p].parity_over = par_over_w[p];
    // fault only while the link is meant to run and no clock is seen
    assign port_if[p].cable_fault =
      link_expected_i[p] & ~link_clk_detect_i[p];
    assign port_if[p].frequency_stable_flag = frequency_stable_flag_i[p];
    assign port_if[p].image_err = image_err_i[p];
    assign port_if[p].events.len_unst = len_unstable_i[p];
    assign port_if[p].events.len_chg = len_chg_i[p];
    assign port_if[p].events.enc = enc_err_i[p];
    assign port_if[p].events.buf_ovf = buf_ovf_i[p];
    assign port_if[p].events.cnt_chg = cnt_chg_i[p];
    assign port_if[p].events.crc = crc_err_i[p];
    assign port_if[p].events.seq = seq_err_i[p];
    // lock change is derived inside the bank
    assign port_if[p].events.lock_chg = 1'b0;
    // only the copy of the selected port is cleared by a read
    assign port_if[p].rd_one =
      reg_rd_i && acc_one_w && (sel_q == 1'(p));
    assign port_if[p].rd_two =
      reg_rd_i && acc_two_w && (sel_q == 1'(p));
    assign port_if[p].sel_port = sel_q;
    assign sts_one_w[p] = port_if[p].sts_one;
    assign sts_two_w[p] = port_if[p].sts_two;

    rx_port_bank u_bank (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .port_io(port_if[p])
    );
  end

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // write and read decode; a read in the same cycle as a select write
  // still returns the port that was selected before the write
  always_comb
  begin
    sel_d = sel_q;
    wen_d = wen_q;
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_wr_i && acc_sel_w)
    begin
      sel_d = reg_wdata_i[`SEL_READ_BIT];
      wen_d = reg_wdata_i[`SEL_WEN_HI:0];
    end
    if (reg_rd_i)
    begin
      case (1'b1)
        acc_sel_w:
        begin
          rdata_d = `SEL_RESET;
          // local access, so the physical port field reads zero
          rdata_d[`SEL_PHYS_BIT] = 1'b0;
          rdata_d[`SEL_READ_BIT] = sel_q;
          rdata_d[`SEL_WEN_HI:0] = wen_q;
        end
        acc_one_w:
        begin
          rdata_d = sts_one_w[sel_q];
        end
        acc_two_w:
        begin
          rdata_d = sts_two_w[sel_q];
        end
        default:
        begin
          rdata_d = 8'h00; // unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_q <= `SEL_READ_RESET;
      wen_q <= `SEL_WEN_RESET;
      rdata_q <= `STS_RESET;
      rvalid_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      wen_q <= wen_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign read_port_o = sel_q;
  assign write_enable_o = wen_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helpers: live levels and second register copy of the selected port
  logic sel_lock_w;
  logic sel_pass_w;
  logic sel_par_w;
  logic sel_cable_w;
  logic sel_img_w;
  reg_byte_t sel_two_w;
  assign sel_lock_w = lock_i[sel_q];
  assign sel_pass_w = pass_i[sel_q];
  assign sel_par_w = par_over_w[sel_q];
  assign sel_cable_w = link_expected_i[sel_q] & ~link_clk_detect_i[sel_q];
  assign sel_img_w = image_err_i[sel_q];
  assign sel_two_w = sts_two_w[sel_q];

  AST_RVALID_TIMING: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i |-> ##`RD_LATENCY reg_rvalid_o)
    else $error("read answer not one cycle after request");
  AST_SEL_FOLLOWS_WRITE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_wr_i && acc_sel_w |=> read_port_o == $past(reg_wdata_i[`SEL_READ_BIT]))
    else $error("read port select not taken from write");
  AST_PORT_NUM: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w |=> reg_rdata_o[`ONE_PORT_NUM] == $past(sel_q))
    else $error("port number bit differs from selected port");
  AST_LOCK_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w |=> reg_rdata_o[`ONE_LOCK] == $past(sel_lock_w))
    else $error("lock bit wrong");
  AST_PASS_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w |=> reg_rdata_o[`ONE_PASS] == $past(sel_pass_w))
    else $error("pass bit wrong");
  AST_PARITY_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w |=> reg_rdata_o[`ONE_PARITY] == $past(sel_par_w))
    else $error("parity flag wrong");
  AST_PARITY_NO_RC: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w && sel_par_w ##1 !reg_rd_i ##1 reg_rd_i && acc_one_w
    && $stable(parity_error_count_i) && sel_par_w
    |=> reg_rdata_o[`ONE_PARITY])
    else $error("parity flag cleared by read");
  AST_CABLE_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_two_w |=> reg_rdata_o[`TWO_CABLE] == $past(sel_cable_w))
    else $error("cable fault bit wrong");
  AST_IMAGE_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_two_w |=> reg_rdata_o[`TWO_IMG] == $past(sel_img_w))
    else $error("image error summary wrong");
  AST_COPY_SELECT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_two_w |=> reg_rdata_o == $past(sel_two_w))
    else $error("second register not from selected port");
  AST_UNMAPPED_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && !acc_sel_w && !acc_one_w && !acc_two_w |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // select register and per-port copy checks
  // ----------------------------------------------------------------
  // an answer only ever follows a request, never a stray strobe
  AST_RVALID_ONLY_READ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without a request");
  // each write enable bit lands in its own place
  AST_WEN_FOLLOWS_WRITE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_wr_i && acc_sel_w |=> write_enable_o == $past(reg_wdata_i[`SEL_WEN_HI:0]))
    else $error("write enables not taken from write");
  // without a select write both select fields hold
  AST_SEL_HOLDS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(reg_wr_i && acc_sel_w) |=> $stable(read_port_o) && $stable(write_enable_o))
    else $error("select fields moved without a write");
  // local access reads the physical port as zero and the old read port
  AST_SEL_READBACK: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_sel_w |=> !reg_rdata_o[`SEL_PHYS_BIT] && reg_rdata_o[`SEL_READ_BIT] == $past(sel_q))
    else $error("select readback wrong");
  // a read clears only the copy of the selected port
  AST_OTHER_ONE_KEPT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_one_w && sel_q && sts_one_w[0][`ONE_CRC] |=> sts_one_w[0][`ONE_CRC])
    else $error("read of port 1 cleared port 0 flag");
  AST_OTHER_TWO_KEPT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && acc_two_w && !sel_q && sts_two_w[1][`TWO_CNT_CHG] |=> sts_two_w[1][`TWO_CNT_CHG])
    else $error("read of port 0 cleared port 1 flag");
endmodule // rx_port_status_registers
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_defines.svh"

// ----------------------------------------------------------------
// bench for the receive port status register pair
// ----------------------------------------------------------------
module tb_top;
  import rx_status_pkg::*;
  localparam int PW = 16;
  // event order: crc, sequence, length unstable, length change, encoding, buffer, line count
  localparam bit [6:0] EV_TWO = 7'b1111100;
  localparam logic [6:0][2:0] EV_BIT = {3'd0, 3'd4, 3'd5, 3'd6, 3'd7, 3'd3, 3'd5};

  logic clk;
  logic rst_n;
  reg_addr_t addr;
  logic rd_en;
  logic wr_en;
  reg_byte_t wdata;
  reg_byte_t rdata;
  logic rvalid;
  logic read_port;
  logic [1:0] wr_enables;
  logic [1:0] lock, pass, freq, img, link_exp, link_det;
  logic [6:0][1:0] ev_drive;
  logic [1:0][PW-1:0] par_cnt, par_thr;
  logic cur_port;
  int num_errors;
  int tests_run;
  reg_byte_t got;

  // ----------------------------------------------------------------
  // clock and device
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #2 clk = ~clk;

  rx_port_status_registers #(
    .NUM_PORTS(2),
    .PAR_CNT_W(PW)
  ) i_dut (
    .core_clk_i(clk),
    .rst_n_i(rst_n),
    .reg_addr_i(addr),
    .reg_rd_i(rd_en),
    .reg_wr_i(wr_en),
    .reg_wdata_i(wdata),
    .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid),
    .read_port_o(read_port),
    .write_enable_o(wr_enables),
    .lock_i(lock),
    .pass_i(pass),
    .frequency_stable_flag_i(freq),
    .image_err_i(img),
    .link_expected_i(link_exp),
    .link_clk_detect_i(link_det),
    .crc_err_i(ev_drive[0]),
    .seq_err_i(ev_drive[1]),
    .len_unstable_i(ev_drive[2]),
    .len_chg_i(ev_drive[3]),
    .enc_err_i(ev_drive[4]),
    .buf_ovf_i(ev_drive[5]),
    .cnt_chg_i(ev_drive[6]),
    .parity_error_count_i(par_cnt),
    .parity_threshold_setting_i(par_thr)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input reg_byte_t exp, input reg_byte_t seen);
    tests_run++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // hit pulses events on the selected port in the read cycle itself
  task automatic reg_rd(input reg_addr_t a, input logic [6:0] hit, output reg_byte_t d);
    int n;
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    for (int k = 0; k < 7; k++)
      ev_drive[k][cur_port] <= hit[k];
    @(posedge clk);
    rd_en <= 1'b0;
    ev_drive <= '0;
    // answer due one cycle after the read edge, bounded wait in case it never comes
    for (n = 0; n < 4; n++)
    begin
      #1;
      if (rvalid === 1'b1)
        break;
      @(posedge clk);
    end
    if (n == 4)
    begin
      $display("mismatch read answer expected 1 seen 0");
      num_errors++;
      stop_test();
    end
    else
      d = rdata;
  endtask

  task automatic rd_chk(input string name, input reg_addr_t a, input reg_byte_t exp);
    reg_byte_t d;
    reg_rd(a, 7'h00, d);
    chk(name, exp, d);
  endtask

  // write enables set for both ports, read port set to p
  task automatic sel(input logic p);
    reg_wr(`ADDR_PORT_SEL, {3'b000, p, 4'h3});
    cur_port = p;
  endtask

  task automatic pulse(input int k, input logic p);
    @(posedge clk);
    ev_drive[k][p] <= 1'b1;
    @(posedge clk);
    ev_drive[k][p] <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reg_addr_t a;
    reg_byte_t base;
    rst_n = 1'b0;
    addr = '0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = '0;
    {lock, pass, freq, img, link_exp, link_det} = '0;
    ev_drive = '0;
    par_cnt = '0;
    par_thr = '0;
    cur_port = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("read port reset", 8'h00, {7'h00, read_port});
    chk("write enables reset", 8'h00, {6'h00, wr_enables});
    rd_chk("select reset", `ADDR_PORT_SEL, `SEL_RESET);
    rd_chk("one reset", `ADDR_STS_ONE, `STS_RESET);
    rd_chk("two reset", `ADDR_STS_TWO, `STS_RESET);
    // reserved select bits and the physical port field must not stick
    reg_wr(`ADDR_PORT_SEL, 8'hff);
    cur_port = 1'b1;
    #1;
    chk("read port", 8'h01, {7'h00, read_port});
    chk("write enables", 8'h03, {6'h00, wr_enables});
    rd_chk("select mask", `ADDR_PORT_SEL, 8'h13);
    reg_wr(`ADDR_STS_ONE, 8'hff);
    rd_chk("one read only", `ADDR_STS_ONE, 8'h40);
    rd_chk("unmapped", 8'h60, 8'h00);
    // a single enable bit catches swapped write enables
    reg_wr(`ADDR_PORT_SEL, 8'h12);
    #1;
    chk("write enable one", 8'h02, {6'h00, wr_enables});
    // opposite level patterns on the two ports catch a wrong copy
    @(posedge clk);
    lock <= 2'b01;
    pass <= 2'b10;
    freq <= 2'b01;
    img <= 2'b10;
    link_exp <= 2'b11;
    link_det <= 2'b10;
    par_thr <= {16'd5, 16'd5};
    par_cnt <= {16'd5, 16'd6};
    sel(1'b0);
    rd_chk("one port0 live", `ADDR_STS_ONE, 8'h15);
    rd_chk("one port0 again", `ADDR_STS_ONE, 8'h05);
    rd_chk("two port0 live", `ADDR_STS_TWO, 8'h06);
    sel(1'b1);
    rd_chk("one port1 live", `ADDR_STS_ONE, 8'h42);
    rd_chk("two port1 live", `ADDR_STS_TWO, 8'h08);
    @(posedge clk);
    lock <= 2'b00;
    par_cnt <= '0;
    sel(1'b0);
    rd_chk("one lock fell", `ADDR_STS_ONE, 8'h10);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      link_exp[0] <= c[1];
      link_det[0] <= c[0];
      rd_chk("cable fault", `ADDR_STS_TWO, (c == 2) ? 8'h06 : 8'h04);
    end
    // every event on each port, the other copy untouched by set or read
    @(posedge clk);
    {pass, freq, img, link_exp, link_det} <= '0;
    for (int k = 0; k < 7; k++)
      for (int p = 0; p < 2; p++)
      begin
        a = EV_TWO[k] ? `ADDR_STS_TWO : `ADDR_STS_ONE;
        base = EV_TWO[k] ? 8'h00 : {1'b0, p[0], 6'h00};
        // event k pulsed for one cycle straight on its input of port p
        pulse(k, p[0]);
        sel(!p[0]);
        rd_chk("event other port", a, EV_TWO[k] ? 8'h00 : {1'b0, !p[0], 6'h00});
        sel(p[0]);
        rd_chk("event set", a, base | (8'h01 << EV_BIT[k]));
        rd_chk("event cleared", a, base);
      end
    // event landing on the clearing read must survive it
    reg_rd(`ADDR_STS_ONE, 7'h01, got);
    chk("crc same cycle", 8'h40, got);
    rd_chk("crc kept", `ADDR_STS_ONE, 8'h60);
    reg_rd(`ADDR_STS_TWO, 7'h40, got);
    chk("count same cycle", 8'h00, got);
    rd_chk("count kept", `ADDR_STS_TWO, 8'h01);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
